// ---- rtl/pscm_pkg.sv ----
// Constants shared by the PHY status and clock monitor register group
package pscm_pkg;

	// ********************************************************************
	// Bus geometry
	// ********************************************************************
	localparam int ADDR_W = 12;
	localparam int IDX_W  = 10;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;

	// ********************************************************************
	// Register indexes; byte address is four times the index
	// ********************************************************************
	localparam logic [IDX_W-1:0] IDX_PLL_LOCK   = 10'h322;
	localparam logic [IDX_W-1:0] IDX_FRM_ERR    = 10'h323;
	localparam logic [IDX_W-1:0] IDX_FRM_CLR    = 10'h324;
	localparam logic [IDX_W-1:0] IDX_SOFT_RST   = 10'h325;
	localparam logic [IDX_W-1:0] IDX_PCS_STAT   = 10'h326;
	localparam logic [IDX_W-1:0] IDX_REFCLK_MON = 10'h340;
	localparam logic [IDX_W-1:0] IDX_RXMAC_MON  = 10'h341;
	localparam logic [IDX_W-1:0] IDX_TXMAC_MON  = 10'h342;
	localparam logic [IDX_W-1:0] IDX_RECCLK_MON = 10'h343;
	localparam logic [IDX_W-1:0] IDX_TXPMA_MON  = 10'h344;

	// ********************************************************************
	// Fields and reset values
	// ********************************************************************
	localparam int NUM_LANES = 20;
	localparam int NUM_MON   = 5;
	localparam int MON_REF   = 0;
	localparam int MON_RXMAC = 1;
	localparam int MON_TXMAC = 2;
	localparam int MON_REC   = 3;
	localparam int MON_TXPMA = 4;
	localparam int BIT_FRM_CLR  = 0;
	localparam int BIT_PCS_RST  = 0;
	localparam int BIT_FIFO_CLR = 1;
	localparam logic [NUM_LANES-1:0] FRM_ERR_RST = 20'hfffff;
	localparam logic                 FRM_CLR_RST = 1'h0;
	localparam logic [1:0]           SOFT_RST_RST = 2'h0;
	localparam logic [DATA_W-1:0]    MON_RST      = 32'h0;

	// ********************************************************************
	// Frequency gate: 1 ms of the 100 MHz status clock gives kHz directly
	// ********************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int GATE_TIME_NS  = 1000000;
	localparam int GATE_CYCLES   = GATE_TIME_NS / CLK_PERIOD_NS;
	localparam int GATE_W        = 17;

endpackage : pscm_pkg

// ---- rtl/pscm_sync.sv ----
// Two-flop level synchroniser for a bundle of asynchronous status inputs
`timescale 1ns/1ps
module pscm_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,     // Status clock
	input  wire logic         i_sys_rst, // Async reset, active high
	input  wire logic [W-1:0] i_async,   // Inputs from another domain
	output logic      [W-1:0] o_sync     // Synchronised copy
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pscm_sync_st_t;

	pscm_sync_st_t q;
	pscm_sync_st_t next_q;

	always_comb begin
		next_q    = q;
		next_q.s1 = i_async;
		next_q.s2 = q.s1;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign o_sync = q.s2;

endmodule : pscm_sync

// ---- rtl/pscm_freq_mon.sv ----
// Edge counter measuring one clock against the shared gate strobe
`timescale 1ns/1ps
module pscm_freq_mon
	import pscm_pkg::*;
(
	input  wire logic              i_clk,       // Status clock
	input  wire logic              i_sys_rst,   // Async reset, active high
	input  wire logic              i_meas,      // Measured clock, sampled as data
	input  wire logic              i_gate_tick, // End of gate, one cycle
	output logic      [DATA_W-1:0] o_khz        // Edges in the last gate
);

	// Sampling limits measurable rate to below half the status clock
	typedef struct packed {
		logic              s1;
		logic              s2;
		logic              s3;
		logic [DATA_W-1:0] cnt;
		logic [DATA_W-1:0] val;
	} pscm_mon_st_t;

	pscm_mon_st_t q;
	pscm_mon_st_t next_q;
	logic         rise;

	assign rise = q.s2 & ~q.s3;

	always_comb begin
		next_q    = q;
		next_q.s1 = i_meas;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		if (i_gate_tick) begin
			// Edge on the tick cycle closes this gate only, never the next
			next_q.val = q.cnt + {31'h0, rise};
			next_q.cnt = '0;
		end else begin
			next_q.cnt = q.cnt + {31'h0, rise};
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign o_khz = q.val;

	property p_gate_load;
		@(posedge i_clk) disable iff (i_sys_rst)
		i_gate_tick |=> (o_khz == $past(q.cnt) + {31'h0, $past(rise)}) && (q.cnt == '0);
	endproperty
	a_gate_load: assert property (p_gate_load) else $error("monitor value not loaded at gate");

endmodule : pscm_freq_mon

// ---- rtl/pscm_top.sv ----
// PHY status, soft reset and clock frequency monitor registers on Avalon-MM
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module pscm_top
	import pscm_pkg::*;
#(
	parameter int unsigned GATE_CYCLES_P     = GATE_CYCLES,
	parameter bit          LINK_FAULT_GEN_EN = 1'b0
) (
	input  wire logic                 i_clk,              // Status clock, 100 MHz
	input  wire logic                 i_sys_rst,          // Async reset, active high
	input  wire logic [ADDR_W-1:0]    i_avs_address,      // Byte address
	input  wire logic                 i_avs_read,         // Read request
	input  wire logic                 i_avs_write,        // Write request
	input  wire logic [BE_W-1:0]      i_avs_byteenable,   // Write byte lanes
	input  wire logic [DATA_W-1:0]    i_avs_writedata,    // Write data
	output logic      [DATA_W-1:0]    o_avs_readdata,     // Read data
	output logic                      o_avs_waitrequest,  // Stall, low answers
	input  wire logic                 i_rx_pll_locked,    // RX PLL lock
	input  wire logic                 i_tx_mac_pll_locked,// TX MAC PLL lock
	input  wire logic                 i_tx_pcs_ready,     // TX PCS ready
	input  wire logic                 i_rx_pcs_aligned,   // RX PCS aligned
	input  wire logic                 i_high_bit_error_rate, // High BER seen
	input  wire logic                 i_lane_align_restart,  // Alignment retry
	input  wire logic [NUM_LANES-1:0] i_lane_frame_err,   // Per-lane frame error
	input  wire logic                 i_refclk,           // Measured clocks
	input  wire logic                 i_rx_mac_clk,       // Measured clocks
	input  wire logic                 i_tx_mac_clk,       // Measured clocks
	input  wire logic                 i_rx_rec_clk,       // Measured clocks
	input  wire logic                 i_tx_pma_clk,       // Measured clocks
	output logic                      o_rx_fifo_clear,    // RX FIFO clear level
	output logic                      o_rx_pcs_reset      // RX PCS reset level
);

	// ********************************************************************
	// State
	// ********************************************************************
	localparam int SYNC_W = NUM_LANES + 6;

	typedef struct packed {
		logic                 waitreq;
		logic [DATA_W-1:0]    rdata;
		logic                 frm_clr;
		logic                 fifo_clr;
		logic                 pcs_rst;
		logic [NUM_LANES-1:0] frm_err;
		logic [GATE_W-1:0]    gate_cnt;
		logic                 gate_tick;
	} pscm_top_st_t;

	pscm_top_st_t q;
	pscm_top_st_t next_q;

	logic [SYNC_W-1:0]  sync_out;
	logic [2:0]         s_pll;
	logic               s_aligned;
	logic               s_hiber;
	logic               s_restart;
	logic [NUM_LANES-1:0] s_lane_err;
	logic               ber_bit;
	logic [NUM_MON-1:0] meas;
	logic [DATA_W-1:0]  mon_khz [NUM_MON];
	logic               rd_first;
	logic               wr_take;

	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
		return a == {idx, 2'b00};
	endfunction : addr_is

	// ********************************************************************
	// Input synchronisation
	// ********************************************************************
	pscm_sync #(
		.W (SYNC_W)
	) u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   ({i_lane_frame_err, i_lane_align_restart, i_high_bit_error_rate,
		             i_rx_pcs_aligned, i_rx_pll_locked, i_tx_mac_pll_locked, i_tx_pcs_ready}),
		.o_sync    (sync_out)
	);

	assign s_pll      = sync_out[2:0];
	assign s_aligned  = sync_out[3];
	assign s_hiber    = sync_out[4];
	assign s_restart  = sync_out[5];
	assign s_lane_err = sync_out[SYNC_W-1:6];
	// Option tied off at build time keeps the bit at zero
	assign ber_bit    = LINK_FAULT_GEN_EN & s_hiber;

	// ********************************************************************
	// Frequency monitors
	// ********************************************************************
	assign meas[MON_REF]   = i_refclk;
	assign meas[MON_RXMAC] = i_rx_mac_clk;
	assign meas[MON_TXMAC] = i_tx_mac_clk;
	assign meas[MON_REC]   = i_rx_rec_clk;
	assign meas[MON_TXPMA] = i_tx_pma_clk;

	for (genvar g = 0; g < NUM_MON; g++) begin : g_mon
		pscm_freq_mon u_mon (
			.i_clk       (i_clk),
			.i_sys_rst   (i_sys_rst),
			.i_meas      (meas[g]),
			.i_gate_tick (q.gate_tick),
			.o_khz       (mon_khz[g])
		);
	end

	// ********************************************************************
	// Bus handshake: answer one cycle after the request appears
	// ********************************************************************
	assign rd_first = i_avs_read & q.waitreq;
	assign wr_take  = i_avs_write & ~q.waitreq;

	// ********************************************************************
	// Next state
	// ********************************************************************
	always_comb begin
		logic [DATA_W-1:0] rd_val;
		rd_val = '0;
		next_q = q;

		// Gate strobe shared by all five monitors
		if (q.gate_cnt == GATE_W'(GATE_CYCLES_P - 1)) begin
			next_q.gate_cnt  = '0;
			next_q.gate_tick = 1'b1;
		end else begin
			next_q.gate_cnt  = q.gate_cnt + 1'b1;
			next_q.gate_tick = 1'b0;
		end

		// Read mux; unmapped addresses read zero
		if (addr_is(i_avs_address, IDX_PLL_LOCK)) begin
			rd_val = {29'h0, s_pll};
		end else if (addr_is(i_avs_address, IDX_FRM_ERR)) begin
			rd_val = {12'h0, q.frm_err};
		end else if (addr_is(i_avs_address, IDX_FRM_CLR)) begin
			rd_val = {31'h0, q.frm_clr};
		end else if (addr_is(i_avs_address, IDX_SOFT_RST)) begin
			rd_val = {30'h0, q.fifo_clr, q.pcs_rst};
		end else if (addr_is(i_avs_address, IDX_PCS_STAT)) begin
			rd_val = {30'h0, ber_bit, s_aligned};
		end else if (addr_is(i_avs_address, IDX_REFCLK_MON)) begin
			rd_val = mon_khz[MON_REF];
		end else if (addr_is(i_avs_address, IDX_RXMAC_MON)) begin
			rd_val = mon_khz[MON_RXMAC];
		end else if (addr_is(i_avs_address, IDX_TXMAC_MON)) begin
			rd_val = mon_khz[MON_TXMAC];
		end else if (addr_is(i_avs_address, IDX_RECCLK_MON)) begin
			rd_val = mon_khz[MON_REC];
		end else if (addr_is(i_avs_address, IDX_TXPMA_MON)) begin
			rd_val = mon_khz[MON_TXPMA];
		end

		if ((i_avs_read | i_avs_write) & q.waitreq) begin
			next_q.waitreq = 1'b0;
			if (i_avs_read) begin
				next_q.rdata = rd_val;
			end
		end else begin
			next_q.waitreq = 1'b1;
		end

		// Writes land on the edge where waitrequest is seen low
		if (wr_take & i_avs_byteenable[0]) begin
			if (addr_is(i_avs_address, IDX_FRM_CLR)) begin
				next_q.frm_clr = i_avs_writedata[BIT_FRM_CLR];
			end else if (addr_is(i_avs_address, IDX_SOFT_RST)) begin
				next_q.fifo_clr = i_avs_writedata[BIT_FIFO_CLR];
				next_q.pcs_rst  = i_avs_writedata[BIT_PCS_RST];
			end
		end

		// Clear bit wins outright; otherwise a new error beats a realign clear
		if (q.frm_clr) begin
			next_q.frm_err = '0;
		end else begin
			next_q.frm_err = (q.frm_err & ~{NUM_LANES{s_restart}}) | s_lane_err;
		end
	end

	// ********************************************************************
	// Registers
	// ********************************************************************
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q.waitreq   <= 1'b1;
			q.rdata     <= '0;
			q.frm_clr   <= FRM_CLR_RST;
			q.fifo_clr  <= SOFT_RST_RST[BIT_FIFO_CLR];
			q.pcs_rst   <= SOFT_RST_RST[BIT_PCS_RST];
			q.frm_err   <= FRM_ERR_RST;
			q.gate_cnt  <= '0;
			q.gate_tick <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	assign o_avs_readdata    = q.rdata;
	assign o_avs_waitrequest = q.waitreq;
	assign o_rx_fifo_clear   = q.fifo_clr;
	assign o_rx_pcs_reset    = q.pcs_rst;

	// ********************************************************************
	// Checks
	// ********************************************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	sequence s_clr_write;
		wr_take && i_avs_byteenable[0] && addr_is(i_avs_address, IDX_FRM_CLR) && i_avs_writedata[0];
	endsequence

	sequence s_flags_cleared;
		q.frm_clr ##1 (q.frm_err == '0);
	endsequence

	property p_pll_read;
		rd_first && addr_is(i_avs_address, IDX_PLL_LOCK) |=> o_avs_readdata == {29'h0, $past(s_pll)};
	endproperty
	a_pll_read: assert property (p_pll_read) else $error("lock word wrong");

	property p_frm_reset;
		$fell(i_sys_rst) |-> q.frm_err == FRM_ERR_RST;
	endproperty
	a_frm_reset: assert property (p_frm_reset) else $error("lane flags not ones after reset");

	property p_frm_read;
		rd_first && addr_is(i_avs_address, IDX_FRM_ERR) |=> o_avs_readdata == {12'h0, $past(q.frm_err)};
	endproperty
	a_frm_read: assert property (p_frm_read) else $error("lane flag read wrong");

	property p_restart_clear;
		s_restart && s_lane_err == '0 |=> q.frm_err == '0;
	endproperty
	a_restart_clear: assert property (p_restart_clear) else $error("realign did not clear flags");

	property p_clr_write;
		s_clr_write |=> s_flags_cleared;
	endproperty
	a_clr_write: assert property (p_clr_write) else $error("clear write did not clear flags");

	property p_hold_zero;
		q.frm_clr [*2] |-> q.frm_err == '0;
	endproperty
	a_hold_zero: assert property (p_hold_zero) else $error("flags not held at zero");

	property p_fifo_hold;
		o_rx_fifo_clear && !(wr_take && addr_is(i_avs_address, IDX_SOFT_RST)) |=> o_rx_fifo_clear;
	endproperty
	a_fifo_hold: assert property (p_fifo_hold) else $error("fifo clear dropped by itself");

	property p_pcs_rst;
		wr_take && i_avs_byteenable[0] && addr_is(i_avs_address, IDX_SOFT_RST)
			|=> o_rx_pcs_reset == $past(i_avs_writedata[BIT_PCS_RST])
			&& o_rx_fifo_clear == $past(i_avs_writedata[BIT_FIFO_CLR]);
	endproperty
	a_pcs_rst: assert property (p_pcs_rst) else $error("soft reset write not taken");

	property p_pcs_hold;
		o_rx_pcs_reset && !(wr_take && addr_is(i_avs_address, IDX_SOFT_RST)) |=> o_rx_pcs_reset;
	endproperty
	a_pcs_hold: assert property (p_pcs_hold) else $error("pcs reset dropped by itself");

	property p_align_read;
		rd_first && addr_is(i_avs_address, IDX_PCS_STAT) |=> o_avs_readdata[0] == $past(s_aligned);
	endproperty
	a_align_read: assert property (p_align_read) else $error("aligned bit wrong");

	property p_ber_read;
		rd_first && addr_is(i_avs_address, IDX_PCS_STAT) |=> o_avs_readdata[31:1] == {30'h0, $past(ber_bit)}
			&& (LINK_FAULT_GEN_EN || !o_avs_readdata[1]);
	endproperty
	a_ber_read: assert property (p_ber_read) else $error("high error rate bit wrong");

	property p_ref_read;
		rd_first && addr_is(i_avs_address, IDX_REFCLK_MON) |=> o_avs_readdata == $past(mon_khz[MON_REF]);
	endproperty
	a_ref_read: assert property (p_ref_read) else $error("refclk monitor read wrong");

	property p_rxmac_read;
		rd_first && addr_is(i_avs_address, IDX_RXMAC_MON) |=> o_avs_readdata == $past(mon_khz[MON_RXMAC]);
	endproperty
	a_rxmac_read: assert property (p_rxmac_read) else $error("rx mac monitor read wrong");

	property p_txmac_read;
		rd_first && addr_is(i_avs_address, IDX_TXMAC_MON) |=> o_avs_readdata == $past(mon_khz[MON_TXMAC]);
	endproperty
	a_txmac_read: assert property (p_txmac_read) else $error("tx mac monitor read wrong");

	property p_rec_read;
		rd_first && addr_is(i_avs_address, IDX_RECCLK_MON) |=> o_avs_readdata == $past(mon_khz[MON_REC]);
	endproperty
	a_rec_read: assert property (p_rec_read) else $error("recovered monitor read wrong");

	property p_txpma_read;
		rd_first && addr_is(i_avs_address, IDX_TXPMA_MON) |=> o_avs_readdata == $past(mon_khz[MON_TXPMA]);
	endproperty
	a_txpma_read: assert property (p_txpma_read) else $error("tx pma monitor read wrong");

	property p_gate_period;
		q.gate_tick |=> !q.gate_tick [*8];
	endproperty
	a_gate_period: assert property (p_gate_period) else $error("gate strobe too frequent");

	property p_answer;
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer timing wrong");

	property p_clr_bit;
		wr_take && i_avs_byteenable[0] && addr_is(i_avs_address, IDX_FRM_CLR)
			|=> q.frm_clr == $past(i_avs_writedata[BIT_FRM_CLR]);
	endproperty
	a_clr_bit: assert property (p_clr_bit) else $error("clear bit write not taken");

	property p_be_ignore;
		wr_take && !i_avs_byteenable[0] |=> $stable({q.frm_clr, q.fifo_clr, q.pcs_rst});
	endproperty
	a_be_ignore: assert property (p_be_ignore) else $error("masked write changed a control bit");

	property p_reset_outs;
		$fell(i_sys_rst) |-> o_avs_waitrequest && !o_rx_fifo_clear && !o_rx_pcs_reset && o_avs_readdata == '0;
	endproperty
	a_reset_outs: assert property (p_reset_outs) else $error("outputs not at reset values");

	property p_rdata_hold;
		!rd_first |=> $stable(o_avs_readdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

endmodule : pscm_top

// ---- tb/tb_top.sv ----
// Self-checking bench for the PHY status and clock monitor register group
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
	$display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_top
	import pscm_pkg::*;
;
	// ********************************************************************
	// Signals and design
	// ********************************************************************
	localparam int GATE_TB = 100;
	localparam int HALF [NUM_MON] = '{2, 5, 10, 25, 50};
	logic                 i_clk = 1'b0;
	logic                 i_sys_rst = 1'b1;
	logic [ADDR_W-1:0]    i_avs_address = '0;
	logic                 i_avs_read = 1'b0;
	logic                 i_avs_write = 1'b0;
	logic [BE_W-1:0]      i_avs_byteenable = '0;
	logic [DATA_W-1:0]    i_avs_writedata = '0;
	logic [DATA_W-1:0]    o_avs_readdata;
	logic                 o_avs_waitrequest;
	logic [2:0]           pll_in = '0;
	logic                 i_rx_pcs_aligned = 1'b0;
	logic                 i_high_bit_error_rate = 1'b0;
	logic                 i_lane_align_restart = 1'b0;
	logic [NUM_LANES-1:0] i_lane_frame_err = '0;
	logic [NUM_MON-1:0]   meas_clk = '0;
	int                   meas_cnt [NUM_MON] = '{0, 0, 0, 0, 0};
	logic                 o_rx_fifo_clear;
	logic                 o_rx_pcs_reset;
	int                   failures = 0;
	int                   check_count = 0;
	logic [DATA_W-1:0]    rd;

	pscm_top #(.GATE_CYCLES_P(GATE_TB), .LINK_FAULT_GEN_EN(1'b0)) u_pscm_top (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_byteenable(i_avs_byteenable), .i_avs_writedata(i_avs_writedata),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
		.i_rx_pll_locked(pll_in[2]), .i_tx_mac_pll_locked(pll_in[1]), .i_tx_pcs_ready(pll_in[0]),
		.i_rx_pcs_aligned(i_rx_pcs_aligned), .i_high_bit_error_rate(i_high_bit_error_rate),
		.i_lane_align_restart(i_lane_align_restart), .i_lane_frame_err(i_lane_frame_err),
		.i_refclk(meas_clk[MON_REF]), .i_rx_mac_clk(meas_clk[MON_RXMAC]),
		.i_tx_mac_clk(meas_clk[MON_TXMAC]), .i_rx_rec_clk(meas_clk[MON_REC]),
		.i_tx_pma_clk(meas_clk[MON_TXPMA]),
		.o_rx_fifo_clear(o_rx_fifo_clear), .o_rx_pcs_reset(o_rx_pcs_reset)
	);

	initial begin
		forever #5 i_clk = ~i_clk;
	end

	// Measured clocks derived from the status clock so edge counts per gate are exact
	always @(posedge i_clk) begin
		for (int k = 0; k < NUM_MON; k++) begin
			if (meas_cnt[k] == HALF[k] - 1) begin
				meas_cnt[k] <= 0;
				meas_clk[k] <= ~meas_clk[k];
			end else begin
				meas_cnt[k] <= meas_cnt[k] + 1;
			end
		end
	end

	// ********************************************************************
	// Bus tasks
	// ********************************************************************
	task automatic bus_xfer(input logic wr, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d,
		input logic [BE_W-1:0] be, output logic [DATA_W-1:0] q);
		int n;
		n = 0;
		i_avs_address <= {idx, 2'b00};
		i_avs_writedata <= d;
		i_avs_byteenable <= be;
		i_avs_read <= ~wr;
		i_avs_write <= wr;
		// Only the watchdog ends a stalled wait
		do begin
			@(posedge i_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		// One stall edge, then the answer edge
		`CHK("wait_cycles", 2, n)
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		// One idle edge so the strobe is never reassigned in the same step
		@(posedge i_clk);
	endtask : bus_xfer

	task automatic wr_reg(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] q;
		bus_xfer(1'b1, idx, d, 4'hf, q);
	endtask : wr_reg

	task automatic chk_reg(input string nm, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] e);
		bus_xfer(1'b0, idx, 32'h0, 4'h0, rd);
		`CHK(nm, e, rd)
	endtask : chk_reg

	// ********************************************************************
	// Scenarios
	// ********************************************************************
	task automatic t_reset_values();
		chk_reg("mon0", IDX_REFCLK_MON, 32'h0);
		chk_reg("mon4", IDX_TXPMA_MON, 32'h0);
		chk_reg("pll", IDX_PLL_LOCK, 32'h0);
		chk_reg("flags", IDX_FRM_ERR, 32'h000fffff);
		chk_reg("clr", IDX_FRM_CLR, 32'h0);
		chk_reg("srst", IDX_SOFT_RST, 32'h0);
		chk_reg("pcs", IDX_PCS_STAT, 32'h0);
		chk_reg("unmapped", 10'h327, 32'h0);
	endtask : t_reset_values

	task automatic t_pll_lock();
		for (int b = 0; b < 3; b++) begin
			pll_in <= 3'(1 << b);
			repeat (4) @(posedge i_clk);
			chk_reg("pll_bit", IDX_PLL_LOCK, 32'(1 << b));
		end
		pll_in <= 3'h0;
	endtask : t_pll_lock

	task automatic t_frame_errors();
		i_lane_frame_err <= 20'h00008;
		wr_reg(IDX_FRM_CLR, 32'h1);
		chk_reg("flags_held", IDX_FRM_ERR, 32'h0);
		chk_reg("clr_rb", IDX_FRM_CLR, 32'h1);
		wr_reg(IDX_FRM_CLR, 32'h0);
		chk_reg("flags_reread", IDX_FRM_ERR, 32'h00000008);
		i_lane_frame_err <= 20'h80001;
		repeat (4) @(posedge i_clk);
		i_lane_frame_err <= 20'h0;
		repeat (4) @(posedge i_clk);
		chk_reg("flags_edge", IDX_FRM_ERR, 32'h00080009);
		i_lane_align_restart <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk_reg("flags_realign", IDX_FRM_ERR, 32'h0);
		i_lane_align_restart <= 1'b0;
	endtask : t_frame_errors

	task automatic t_soft_reset();
		logic [DATA_W-1:0] q;
		wr_reg(IDX_SOFT_RST, 32'h2);
		repeat (20) @(posedge i_clk);
		`CHK("fifo_clr", 1'b1, o_rx_fifo_clear)
		`CHK("pcs_rst", 1'b0, o_rx_pcs_reset)
		wr_reg(IDX_SOFT_RST, 32'h1);
		repeat (20) @(posedge i_clk);
		`CHK("pcs_rst_hold", 1'b1, o_rx_pcs_reset)
		`CHK("fifo_off", 1'b0, o_rx_fifo_clear)
		chk_reg("srst_rb", IDX_SOFT_RST, 32'h1);
		bus_xfer(1'b1, IDX_SOFT_RST, 32'h2, 4'h0, q);
		chk_reg("srst_be0", IDX_SOFT_RST, 32'h1);
		bus_xfer(1'b1, 10'h3ff, 32'h2, 4'hf, q);
		chk_reg("srst_unmapped", IDX_SOFT_RST, 32'h1);
		wr_reg(IDX_SOFT_RST, 32'h0);
		`CHK("pcs_rel", 1'b0, o_rx_pcs_reset)
	endtask : t_soft_reset

	task automatic t_pcs_status();
		i_high_bit_error_rate <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk_reg("pcs_ber_off", IDX_PCS_STAT, 32'h0);
		i_rx_pcs_aligned <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk_reg("pcs_aligned", IDX_PCS_STAT, 32'h1);
		i_rx_pcs_aligned <= 1'b0;
		i_high_bit_error_rate <= 1'b0;
	endtask : t_pcs_status

	task automatic t_monitors();
		repeat (2 * GATE_TB + 10) @(posedge i_clk);
		chk_reg("mon_ref", IDX_REFCLK_MON, 32'(GATE_TB / (2 * HALF[MON_REF])));
		chk_reg("mon_rxmac", IDX_RXMAC_MON, 32'(GATE_TB / (2 * HALF[MON_RXMAC])));
		chk_reg("mon_txmac", IDX_TXMAC_MON, 32'(GATE_TB / (2 * HALF[MON_TXMAC])));
		chk_reg("mon_rec", IDX_RECCLK_MON, 32'(GATE_TB / (2 * HALF[MON_REC])));
		chk_reg("mon_txpma", IDX_TXPMA_MON, 32'(GATE_TB / (2 * HALF[MON_TXPMA])));
		repeat (GATE_TB) @(posedge i_clk);
		chk_reg("mon_steady", IDX_REFCLK_MON, 32'(GATE_TB / (2 * HALF[MON_REF])));
	endtask : t_monitors

	// ********************************************************************
	// Verdict and main sequence
	// ********************************************************************
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (16) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		t_reset_values();
		t_pll_lock();
		t_frame_errors();
		t_soft_reset();
		t_pcs_status();
		t_monitors();
		final_report();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge i_clk);
		failures++;
		final_report();
	end
endmodule : tb_top
